// file: common/ext_bus_pkg.sv
// constants and types shared by the external memory bus interface
package ext_bus_pkg;
  localparam logic [15:0] RESET_FETCH_ADDR = 16'h0000;
  localparam logic [15:0] BOOT_USER_BASE   = 16'hF800;
  localparam logic [15:0] BOOT_PROG_LIMIT  = 16'h0800;
  localparam logic [7:0]  PAGE_REG_ADDR    = 8'h92;
  localparam logic [7:0]  PAGE_RESET       = 8'h00;
  localparam logic [6:0]  CFG_BYTE_ONE_IDX = 7'h7E;
  localparam logic [6:0]  CFG_BYTE_ZERO_IDX = 7'h7F;
  localparam logic [7:0]  CFG_RESET        = 8'hFF;
  localparam int          BUS_SEL_LSB      = 0;
  localparam int          BUS_SEL_MSB      = 1;
  localparam logic [7:0]  HIDDEN_DATA      = 8'h00;
  localparam logic [7:0]  FLOAT_READ       = 8'hFF;
  localparam logic [7:0]  ZERO_BYTE        = 8'h00;
  localparam logic [1:0]  STROBE_CYCLES    = 2'h2;
  localparam logic [1:0]  KIND_FETCH       = 2'h0;
  localparam logic [1:0]  KIND_READ        = 2'h1;
  localparam logic [1:0]  KIND_WRITE       = 2'h2;
  typedef enum logic [1:0] {MODE_USER, MODE_SERIAL, MODE_PARALLEL, MODE_RESERVED} op_mode_e;
endpackage

// file: rtl/config_store.sv
// configuration byte memory with registered read data
module config_store #(
  parameter int DEPTH = 128,
  parameter int AW    = 7
) (
  input  wire logic          i_clk,
  input  wire logic          i_rst,
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_addr,
  input  wire logic [7:0]    i_wdata,
  output logic      [7:0]    o_rdata
);
  logic [7:0]       mem_r [DEPTH];
  logic [DEPTH-1:0] written_r;

  initial begin
    if (DEPTH > (1 << AW)) $error("config_store: DEPTH exceeds address range");
  end

  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem_r[i_addr] <= i_wdata;
    end
  end

  // words not written since reset read as erased, matching the parent's shadows
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      written_r <= '0;
      o_rdata   <= ext_bus_pkg::CFG_RESET;
    end else begin
      if (i_we) begin
        written_r[i_addr] <= 1'b1;
      end
      o_rdata <= written_r[i_addr] ? mem_r[i_addr] : ext_bus_pkg::CFG_RESET;
    end
  end
endmodule // config_store

// file: rtl/external_memory_bus_interface.sv
// multiplexed external memory bus, code map decode and reset strap sampling
// Overview of operation
// - after every reset the first fetch address offered is 0000h
// - strap high: fetches beyond internal program memory go external
// - strap low at reset: every later code and data access outside the boot ROM goes external
// - user mode with boot ROM enabled: boot ROM decodes F800h to FFFFh
// - programming mode: boot ROM decodes the lowest 2kB of program space
// - bus enabled only when config byte one bits 0 and 1 are both zero
// - bus enabled: every access, internal or external, shows on ports 0 and 2
// - internal access shown on bus drives port 0 to zero in data phase
// - program reads use program store strobe; data uses read and write strobes
// - fetches and pointer moves give 16-bit address; index moves give 8-bit
// - bus enabled: port 2 not general I/O; P3.6/P3.7 become write/read strobes
// - index moves hold the page register (92h) on port 2 all cycle
// - port 0 multiplexes address and data, driven actively both levels
// - low address byte valid at falling edge of address latch strobe
// - write data on port 0 from the same edge the write strobe falls until after release
// - read data sampled on port 0 one clock before read strobe release
// - ports default to general I/O; external access then leaves pins unchanged
// - configuration bytes writable only in programming mode
// - external fetches put program counter high byte on port 2
// - straps at reset: 01 serial, 10 parallel, 11 user, 00 reserved
// - programming mode is left only by a reset selecting user or reserved mode
// - internal data never shows on port 0, even with bus enabled
module external_memory_bus_interface #(
  parameter int PM_BYTES   = 32768,
  parameter int XRAM_BYTES = 1024
) (
  input  wire logic        I_CLK,
  input  wire logic        I_RST,
  input  wire logic        I_REQ,
  input  wire logic [1:0]  I_KIND,
  input  wire logic        I_INDEX8,
  input  wire logic [15:0] I_ADDR,
  input  wire logic [7:0]  I_WDATA,
  input  wire logic [7:0]  I_INT_RDATA,
  input  wire logic        I_BOOTROM_EN,
  output logic             O_BUSY,
  output logic             O_ACK,
  output logic [7:0]       O_RDATA,
  output logic             O_EXTERNAL,
  output logic             O_BOOTROM_HIT,
  output logic [15:0]      O_START_ADDR,
  input  wire logic        I_SFR_WE,
  input  wire logic [7:0]  I_SFR_ADDR,
  input  wire logic [7:0]  I_SFR_WDATA,
  output logic [7:0]       O_SFR_RDATA,
  input  wire logic        I_CFG_WE,
  input  wire logic [6:0]  I_CFG_ADDR,
  input  wire logic [7:0]  I_CFG_WDATA,
  output logic [7:0]       O_CFG_RDATA,
  output logic             O_PROG_MODE,
  output logic [1:0]       O_MODE,
  input  wire logic        I_EXT_ACCESS_STRAP_N,
  input  wire logic [7:0]  I_P0_LATCH,
  input  wire logic [7:0]  I_P2_LATCH,
  input  wire logic        I_P36_LATCH,
  input  wire logic        I_P37_LATCH,
  input  wire logic [7:0]  I_P0,
  output logic [7:0]       O_P0,
  output logic             O_P0_OE_N,
  output logic [7:0]       O_P2,
  output logic             O_P36,
  output logic             O_P37,
  input  wire logic        I_ALE,
  output logic             O_ALE,
  input  wire logic        I_PROGRAM_STORE_STROBE_N,
  output logic             O_PROGRAM_STORE_STROBE_N,
  output logic             O_CTL_OE_N
);
  typedef enum logic [2:0] {ST_STRAP, ST_IDLE, ST_ADDR, ST_HOLD, ST_STROBE, ST_RELEASE,
                            ST_DONE} bus_state_e;

  initial begin
    if (PM_BYTES > 65536 || XRAM_BYTES > 65536) $error("memory sizes exceed 64kB map");
  end

  localparam logic [1:0] STROBE_LAST = ext_bus_pkg::STROBE_CYCLES - 2'h1;

  function automatic logic boot_hit(input ext_bus_pkg::op_mode_e m, input logic en,
                                    input logic [15:0] a);
    logic prog;
    prog = (m == ext_bus_pkg::MODE_SERIAL) || (m == ext_bus_pkg::MODE_PARALLEL);
    if (prog) return a < ext_bus_pkg::BOOT_PROG_LIMIT;
    return (m == ext_bus_pkg::MODE_USER) && en && (a >= ext_bus_pkg::BOOT_USER_BASE);
  endfunction

  bus_state_e             state_r, state_nxt;
  ext_bus_pkg::op_mode_e  mode_r, mode_nxt;
  logic        all_ext_r, all_ext_nxt;
  logic [7:0]  cfg_one_r, cfg_one_nxt, cfg_zero_r, cfg_zero_nxt, page_r, page_nxt;
  logic [1:0]  kind_r, kind_nxt, cnt_r, cnt_nxt;
  logic [15:0] addr_r, addr_nxt;
  logic [7:0]  wdata_r, wdata_nxt;
  logic        ext_r, ext_nxt, prog_mode, bus_en, cfg_wr_ok;
  logic [7:0]  rdata_nxt, p0_nxt, p2_nxt, sfr_rdata_nxt;
  logic        ack_nxt, ext_out_nxt, boot_nxt, busy_nxt, p0_oe_n_nxt, p36_nxt, p37_nxt;
  logic        ale_nxt, program_store_strobe_n_nxt, ctl_oe_n_nxt, in_prog, in_boot, in_ext;
  logic [15:0] req_addr;

  assign prog_mode = (mode_r == ext_bus_pkg::MODE_SERIAL) ||
                     (mode_r == ext_bus_pkg::MODE_PARALLEL);
  assign bus_en    = (cfg_one_r[ext_bus_pkg::BUS_SEL_MSB:ext_bus_pkg::BUS_SEL_LSB] == 2'h0);
  assign cfg_wr_ok = I_CFG_WE && prog_mode && (state_r != ST_STRAP);

  config_store #(.DEPTH(128), .AW(7)) u_cfg (
    .i_clk   (I_CLK),
    .i_rst   (I_RST),
    .i_we    (cfg_wr_ok),
    .i_addr  (I_CFG_ADDR),
    .i_wdata (I_CFG_WDATA),
    .o_rdata (O_CFG_RDATA)
  );

  // request decode and control state
  always_comb begin
    state_nxt    = state_r;
    mode_nxt     = mode_r;
    all_ext_nxt  = all_ext_r;
    cfg_one_nxt  = cfg_one_r;
    cfg_zero_nxt = cfg_zero_r;
    page_nxt     = page_r;
    kind_nxt     = kind_r;
    addr_nxt     = addr_r;
    wdata_nxt    = wdata_r;
    ext_nxt      = ext_r;
    cnt_nxt      = cnt_r;
    rdata_nxt    = O_RDATA;
    ack_nxt      = 1'b0;
    ext_out_nxt  = O_EXTERNAL;
    boot_nxt     = O_BOOTROM_HIT;
    // index moves: page register forms the high byte
    req_addr = I_INDEX8 ? {page_r, I_ADDR[7:0]} : I_ADDR;
    in_boot  = (I_KIND == ext_bus_pkg::KIND_FETCH) && boot_hit(mode_r, I_BOOTROM_EN, I_ADDR);
    in_prog  = (I_KIND == ext_bus_pkg::KIND_FETCH) ? (32'(I_ADDR) < PM_BYTES)
                                                   : (32'(req_addr) < XRAM_BYTES);
    in_ext   = !in_boot && (all_ext_r || !in_prog);
    if (cfg_wr_ok && I_CFG_ADDR == ext_bus_pkg::CFG_BYTE_ONE_IDX) cfg_one_nxt = I_CFG_WDATA;
    if (cfg_wr_ok && I_CFG_ADDR == ext_bus_pkg::CFG_BYTE_ZERO_IDX) cfg_zero_nxt = I_CFG_WDATA;
    if (I_SFR_WE && I_SFR_ADDR == ext_bus_pkg::PAGE_REG_ADDR) page_nxt = I_SFR_WDATA;
    sfr_rdata_nxt = (I_SFR_ADDR == ext_bus_pkg::PAGE_REG_ADDR) ? page_r : ext_bus_pkg::ZERO_BYTE;
    case (state_r)
      ST_STRAP: begin
        // straps are read once, so mode only changes across a reset
        all_ext_nxt = !I_EXT_ACCESS_STRAP_N;
        case ({I_PROGRAM_STORE_STROBE_N, I_ALE})
          2'b01:   mode_nxt = ext_bus_pkg::MODE_SERIAL;
          2'b10:   mode_nxt = ext_bus_pkg::MODE_PARALLEL;
          2'b11:   mode_nxt = ext_bus_pkg::MODE_USER;
          default: mode_nxt = ext_bus_pkg::MODE_RESERVED;
        endcase
        state_nxt = ST_IDLE;
      end
      ST_IDLE: begin
        if (I_REQ) begin
          kind_nxt    = I_KIND;
          addr_nxt    = (I_KIND == ext_bus_pkg::KIND_FETCH) ? I_ADDR : req_addr;
          wdata_nxt   = I_WDATA;
          ext_nxt     = in_ext;
          ext_out_nxt = in_ext;
          boot_nxt    = in_boot;
          cnt_nxt     = 2'h0;
          // ports in general I/O mode: cycle completes without touching pins
          state_nxt   = bus_en ? ST_ADDR : ST_DONE;
          if (!bus_en) rdata_nxt = in_ext ? ext_bus_pkg::FLOAT_READ : I_INT_RDATA;
        end
      end
      ST_ADDR:    state_nxt = ST_HOLD;
      ST_HOLD:    state_nxt = ST_STROBE;
      ST_STROBE: begin
        cnt_nxt = cnt_r + 2'h1;
        if (cnt_r == STROBE_LAST) begin
          if (kind_r != ext_bus_pkg::KIND_WRITE) rdata_nxt = ext_r ? I_P0 : I_INT_RDATA;
          state_nxt = ST_RELEASE;
        end
      end
      ST_RELEASE: state_nxt = ST_DONE;
      ST_DONE: begin
        ack_nxt   = 1'b1;
        state_nxt = ST_IDLE;
      end
      default:    state_nxt = ST_IDLE;
    endcase
    busy_nxt = (state_nxt != ST_IDLE);
  end

  // pin values follow the current state one clock later
  always_comb begin
    p0_nxt       = I_P0_LATCH;
    p0_oe_n_nxt  = 1'b0;
    p2_nxt       = I_P2_LATCH;
    p36_nxt      = I_P36_LATCH;
    p37_nxt      = I_P37_LATCH;
    ale_nxt      = 1'b0;
    program_store_strobe_n_nxt   = 1'b1;
    ctl_oe_n_nxt = (state_r == ST_STRAP);
    if (bus_en) begin
      p2_nxt      = O_P2;
      p0_nxt      = O_P0;
      p0_oe_n_nxt = 1'b1;
      p36_nxt     = 1'b1;
      p37_nxt     = 1'b1;
      case (state_r)
        ST_ADDR, ST_HOLD: begin
          ale_nxt     = (state_r == ST_ADDR);
          p0_nxt      = addr_r[7:0];
          p0_oe_n_nxt = 1'b0;
          p2_nxt      = addr_r[15:8];
        end
        ST_STROBE, ST_RELEASE: begin
          p2_nxt = addr_r[15:8];
          if (kind_r == ext_bus_pkg::KIND_WRITE || !ext_r) begin
            // internal cycles expose zeros, never the stored byte
            p0_nxt      = ext_r ? wdata_r : ext_bus_pkg::HIDDEN_DATA;
            p0_oe_n_nxt = 1'b0;
          end
          if (ext_r && state_r == ST_STROBE) begin
            program_store_strobe_n_nxt = (kind_r != ext_bus_pkg::KIND_FETCH);
            p37_nxt    = (kind_r != ext_bus_pkg::KIND_READ);
            p36_nxt    = (kind_r != ext_bus_pkg::KIND_WRITE);
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      state_r       <= ST_STRAP;
      mode_r        <= ext_bus_pkg::MODE_USER;
      all_ext_r     <= 1'b0;
      cfg_one_r     <= ext_bus_pkg::CFG_RESET;
      cfg_zero_r    <= ext_bus_pkg::CFG_RESET;
      page_r        <= ext_bus_pkg::PAGE_RESET;
      kind_r        <= ext_bus_pkg::KIND_FETCH;
      addr_r        <= ext_bus_pkg::RESET_FETCH_ADDR;
      wdata_r       <= ext_bus_pkg::ZERO_BYTE;
      ext_r         <= 1'b0;
      cnt_r         <= 2'h0;
      O_START_ADDR  <= ext_bus_pkg::RESET_FETCH_ADDR;
      O_RDATA       <= ext_bus_pkg::ZERO_BYTE;
      O_ACK         <= 1'b0;
      O_BUSY        <= 1'b1;
      O_EXTERNAL    <= 1'b0;
      O_BOOTROM_HIT <= 1'b0;
      O_SFR_RDATA   <= ext_bus_pkg::ZERO_BYTE;
      O_PROG_MODE   <= 1'b0;
      O_MODE        <= 2'h0;
      O_P0          <= ext_bus_pkg::ZERO_BYTE;
      O_P0_OE_N     <= 1'b1;
      O_P2          <= ext_bus_pkg::CFG_RESET;
      O_P36         <= 1'b1;
      O_P37         <= 1'b1;
      O_ALE         <= 1'b0;
      O_PROGRAM_STORE_STROBE_N <= 1'b1;
      O_CTL_OE_N    <= 1'b1;
    end else begin
      state_r       <= state_nxt;
      mode_r        <= mode_nxt;
      all_ext_r     <= all_ext_nxt;
      cfg_one_r     <= cfg_one_nxt;
      cfg_zero_r    <= cfg_zero_nxt;
      page_r        <= page_nxt;
      kind_r        <= kind_nxt;
      addr_r        <= addr_nxt;
      wdata_r       <= wdata_nxt;
      ext_r         <= ext_nxt;
      cnt_r         <= cnt_nxt;
      O_START_ADDR  <= ext_bus_pkg::RESET_FETCH_ADDR;
      O_RDATA       <= rdata_nxt;
      O_ACK         <= ack_nxt;
      O_BUSY        <= busy_nxt;
      O_EXTERNAL    <= ext_out_nxt;
      O_BOOTROM_HIT <= boot_nxt;
      O_SFR_RDATA   <= sfr_rdata_nxt;
      O_PROG_MODE   <= (mode_nxt == ext_bus_pkg::MODE_SERIAL) ||
                       (mode_nxt == ext_bus_pkg::MODE_PARALLEL);
      O_MODE        <= mode_nxt;
      O_P0          <= p0_nxt;
      O_P0_OE_N     <= p0_oe_n_nxt;
      O_P2          <= p2_nxt;
      O_P36         <= p36_nxt;
      O_P37         <= p37_nxt;
      O_ALE         <= ale_nxt;
      O_PROGRAM_STORE_STROBE_N <= program_store_strobe_n_nxt;
      O_CTL_OE_N    <= ctl_oe_n_nxt;
    end
  end

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);

  sequence ale_pulse_s;
    $rose(O_ALE) ##1 (!O_ALE && $stable(O_P0) && !O_P0_OE_N);
  endsequence

  chk_start_addr: assert property (O_START_ADDR == ext_bus_pkg::RESET_FETCH_ADDR)
    else $error("start address not 0000h");
  chk_user_boot: assert property ((state_r == ST_IDLE && I_REQ && mode_r ==
    ext_bus_pkg::MODE_USER && I_KIND == ext_bus_pkg::KIND_FETCH && I_BOOTROM_EN &&
    I_ADDR >= ext_bus_pkg::BOOT_USER_BASE) |=> (O_BOOTROM_HIT && !O_EXTERNAL))
    else $error("user boot ROM not decoded");
  chk_prog_boot: assert property ((state_r == ST_IDLE && I_REQ && prog_mode &&
    I_KIND == ext_bus_pkg::KIND_FETCH) |=>
    (O_BOOTROM_HIT == ($past(I_ADDR) < ext_bus_pkg::BOOT_PROG_LIMIT)))
    else $error("programming boot ROM map wrong");
  chk_gpio_pins: assert property ((state_r != ST_STRAP && !bus_en) |=>
    (O_P0 == $past(I_P0_LATCH) && O_P2 == $past(I_P2_LATCH) && !O_ALE))
    else $error("general I/O pins disturbed");
  chk_ale_once: assert property ((state_r == ST_ADDR) |=> ale_pulse_s)
    else $error("address latch strobe malformed");
  chk_hidden_zero: assert property ((state_r == ST_STROBE && !ext_r && bus_en) |=>
    (O_P0 == ext_bus_pkg::HIDDEN_DATA && !O_P0_OE_N))
    else $error("internal data exposed");
  chk_write_hold: assert property ($rose(O_P36) && bus_en |->
    ($past(O_P0, 2) == O_P0 && !O_P0_OE_N && !$past(O_P0_OE_N, 3)))
    else $error("write data not held around strobe");
  chk_page_hold: assert property ((state_r == ST_ADDR && kind_r != ext_bus_pkg::KIND_FETCH &&
    addr_r[15:8] == page_r) |=> (O_P2 == page_r) [*4])
    else $error("page byte not held");
  chk_mode_fixed: assert property ((state_r != ST_STRAP) |=> $stable(mode_r))
    else $error("mode changed without reset");
  chk_cfg_locked: assert property ((!prog_mode && state_r != ST_STRAP) |=>
    $stable(cfg_one_r))
    else $error("config byte written outside programming mode");
endmodule // external_memory_bus_interface

// file: tb/ext_mem_model.sv
// external program/data memory behind an address latch
module ext_mem_model (
  input  wire logic       i_ale,
  input  wire logic [7:0] i_ad,
  input  wire logic [7:0] i_hi,
  input  wire logic       i_program_store_strobe_n,
  input  wire logic       i_rd_n,
  input  wire logic       i_wr_n,
  output logic      [7:0] o_ad
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] lat_addr = 16'h0000;
  logic [7:0]  hi_at_strobe = 8'h00;
  logic [1:0]  last_kind = 2'h3;
  logic [7:0]  last_out = 8'h00;
  int          strobes = 0;
  int          ales = 0;
  logic [7:0]  mem [logic [15:0]];

  always @(negedge i_ale) begin
    lat_addr = {i_hi, i_ad};
    ales++;
  end
  always @(negedge i_program_store_strobe_n or negedge i_rd_n or negedge i_wr_n) begin
    hi_at_strobe = i_hi;
    strobes++;
    last_kind = !i_program_store_strobe_n ? 2'h0 : (!i_rd_n ? 2'h1 : 2'h2);
  end
  always @(posedge i_wr_n) mem[lat_addr] = i_ad;
  always @(posedge i_rd_n or posedge i_program_store_strobe_n) last_out = o_ad;
  // released bus shows the inverse so a stale byte never passes for data
  always @* begin
    if (!i_rd_n || !i_program_store_strobe_n) begin
      o_ad = mem.exists(lat_addr) ? mem[lat_addr] : (lat_addr[7:0] ^ lat_addr[15:8] ^ 8'h5A);
    end else begin
      o_ad = ~last_out;
    end
  end
endmodule // ext_mem_model

// file: tb/external_memory_bus_interface_tb.sv
// self-checking bench for the external memory bus interface
module external_memory_bus_interface_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rst = 1'b1, req = 1'b0, idx8 = 1'b0, boot_en = 1'b0;
  logic [1:0]  kind = 2'h0;
  logic [15:0] addr = 16'h0000;
  logic [7:0]  wdata = 8'h00, sfr_addr = 8'h00, sfr_wd = 8'h00, cfg_wd = 8'h00;
  logic        sfr_we = 1'b0, cfg_we = 1'b0, ea_n = 1'b1, s_ale = 1'b1, s_program_store_strobe = 1'b1;
  logic [6:0]  cfg_addr = 7'h00;
  logic        busy, ack, ext, boot_hit, prog, p0oe_n, p36, p37, ale_o, program_store_strobe_o, ctl_oe_n;
  logic [7:0]  rdata, sfr_rd, cfg_rd, p0o, p2, mdl_ad;
  logic [15:0] start;
  logic [1:0]  mode;
  wire  [7:0]  p0w = !p0oe_n ? p0o : mdl_ad;
  wire         alew = ctl_oe_n ? s_ale : ale_o;
  wire         psenw = ctl_oe_n ? s_program_store_strobe : program_store_strobe_o;
  int          errors = 0, samples_checked = 0;

  always #12.5 clk = ~clk;

  external_memory_bus_interface dut (.I_CLK(clk), .I_RST(rst), .I_REQ(req), .I_KIND(kind),
    .I_INDEX8(idx8), .I_ADDR(addr), .I_WDATA(wdata), .I_INT_RDATA(8'hC3),
    .I_BOOTROM_EN(boot_en), .O_BUSY(busy), .O_ACK(ack), .O_RDATA(rdata), .O_EXTERNAL(ext),
    .O_BOOTROM_HIT(boot_hit), .O_START_ADDR(start), .I_SFR_WE(sfr_we), .I_SFR_ADDR(sfr_addr),
    .I_SFR_WDATA(sfr_wd), .O_SFR_RDATA(sfr_rd), .I_CFG_WE(cfg_we), .I_CFG_ADDR(cfg_addr),
    .I_CFG_WDATA(cfg_wd), .O_CFG_RDATA(cfg_rd), .O_PROG_MODE(prog), .O_MODE(mode),
    .I_EXT_ACCESS_STRAP_N(ea_n), .I_P0_LATCH(8'h11), .I_P2_LATCH(8'h22), .I_P36_LATCH(1'b1),
    .I_P37_LATCH(1'b1), .I_P0(p0w), .O_P0(p0o), .O_P0_OE_N(p0oe_n), .O_P2(p2), .O_P36(p36),
    .O_P37(p37), .I_ALE(alew), .O_ALE(ale_o), .I_PROGRAM_STORE_STROBE_N(psenw),
    .O_PROGRAM_STORE_STROBE_N(program_store_strobe_o), .O_CTL_OE_N(ctl_oe_n));

  ext_mem_model mdl (.i_ale(alew), .i_ad(p0w), .i_hi(p2), .i_program_store_strobe_n(psenw), .i_rd_n(p37),
    .i_wr_n(p36), .o_ad(mdl_ad));

  task automatic finish_test();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic do_reset(input logic e, input logic ps, input logic al);
    ea_n = e;
    s_program_store_strobe = ps;
    s_ale = al;
    rst = 1'b1;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
  endtask

  // called at a falling edge; returns falling edges from the call until acknowledge is seen
  task automatic access(input logic [1:0] k, input logic i8, input logic [15:0] a,
                        input logic [7:0] d, output int lat);
    kind = k;
    idx8 = i8;
    addr = a;
    wdata = d;
    req = 1'b1;
    @(negedge clk);
    req = 1'b0;
    lat = 1;
    while (ack !== 1'b1 && lat < 20) begin
      @(negedge clk);
      lat++;
    end
    if (ack !== 1'b1) begin
      errors++;
      $display("ERROR %0t: no acknowledge", $time);
      finish_test();
    end
  endtask

  task automatic reg_wr(input logic c, input logic [7:0] a, input logic [7:0] d);
    cfg_addr = a[6:0];
    cfg_wd = d;
    cfg_we = c;
    sfr_addr = a;
    sfr_wd = d;
    sfr_we = !c;
    @(negedge clk);
    cfg_we = 1'b0;
    sfr_we = 1'b0;
    @(negedge clk);
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    $display("ERROR %0t: run timed out", $time);
    finish_test();
  end

  initial begin
    logic [1:0] em [4];
    int lat, s0, a0;
    em = '{ext_bus_pkg::MODE_RESERVED, ext_bus_pkg::MODE_SERIAL, ext_bus_pkg::MODE_PARALLEL,
           ext_bus_pkg::MODE_USER};
    for (int i = 0; i < 4; i++) begin
      do_reset(1'b1, i[1], i[0]);
      check(mode, em[i]);
      check(prog, i == 1 || i == 2);
      check(start, ext_bus_pkg::RESET_FETCH_ADDR);
    end
    boot_en = 1'b1;
    access(2'h0, 1'b0, 16'hF800, 8'h00, lat); check(boot_hit, 1'b1);
    access(2'h0, 1'b0, 16'hF7FF, 8'h00, lat); check(boot_hit, 1'b0);
    access(2'h0, 1'b0, 16'h9000, 8'h00, lat); check(ext, 1'b1);
    access(2'h0, 1'b0, 16'h0100, 8'h00, lat); check(ext, 1'b0);
    s0 = mdl.strobes;
    access(2'h1, 1'b0, 16'h1234, 8'h00, lat);
    check(lat, 2);
    check({p0oe_n, p0o, p2, p36, p37, rdata}, {1'b0, 8'h11, 8'h22, 2'b11, 8'hFF});
    check(mdl.strobes, s0);
    reg_wr(1'b1, 8'h7E, 8'hFC); check(cfg_rd, ext_bus_pkg::CFG_RESET);
    reg_wr(1'b0, 8'h92, 8'h3C); check(sfr_rd, 8'h3C);
    reg_wr(1'b0, 8'h93, 8'h5F); check(sfr_rd, ext_bus_pkg::ZERO_BYTE);
    do_reset(1'b1, 1'b0, 1'b1);
    sfr_addr = 8'h92;
    @(negedge clk);
    check(sfr_rd, ext_bus_pkg::PAGE_RESET);
    boot_en = 1'b0;
    access(2'h0, 1'b0, 16'h0100, 8'h00, lat); check(boot_hit, 1'b1);
    access(2'h0, 1'b0, 16'h0800, 8'h00, lat); check(boot_hit, 1'b0);
    reg_wr(1'b1, 8'h7E, 8'hFC); check(cfg_rd, 8'hFC);
    reg_wr(1'b0, 8'h92, 8'h3C);
    check({p36, p37}, 2'b11);
    s0 = mdl.strobes;
    a0 = mdl.ales;
    access(2'h2, 1'b0, 16'h2345, 8'hA7, lat); check(lat, 7);
    check({mdl.last_kind, mdl.lat_addr}, {2'h2, 16'h2345});
    access(2'h1, 1'b0, 16'h2345, 8'h00, lat); check(rdata, 8'hA7);
    check({mdl.last_kind, 16'(mdl.strobes - s0), 16'(mdl.ales - a0)},
          {2'h1, 16'h2, 16'h2});
    access(2'h1, 1'b0, 16'h1234, 8'h00, lat); check(rdata, 8'h34 ^ 8'h12 ^ 8'h5A);
    access(2'h0, 1'b0, 16'h9000, 8'h00, lat); check(rdata, 8'hCA);
    check({mdl.last_kind, mdl.hi_at_strobe, mdl.lat_addr}, {2'h0, 8'h90, 16'h9000});
    access(2'h1, 1'b1, 16'h0077, 8'h00, lat); check(rdata, 8'h3C ^ 8'h77 ^ 8'h5A);
    check({mdl.hi_at_strobe, mdl.lat_addr}, {8'h3C, 16'h3C77});
    s0 = mdl.strobes;
    a0 = mdl.ales;
    access(2'h1, 1'b0, 16'h0010, 8'h00, lat); check(rdata, 8'hC3);
    check({16'(mdl.strobes - s0), 16'(mdl.ales - a0), mdl.lat_addr},
          {16'h0, 16'h1, 16'h0010});
    do_reset(1'b0, 1'b1, 1'b1);
    access(2'h0, 1'b0, 16'h0100, 8'h00, lat); check(ext, 1'b1);
    access(2'h1, 1'b0, 16'h0010, 8'h00, lat); check(ext, 1'b1);
    finish_test();
  end
endmodule // external_memory_bus_interface_tb
